/* File: logic/mpt_pkg.sv */
// Shared constants and carrier types for the match based PWM timer.
// Assumes one clock domain and software control through plain ports.
package mpt_pkg;

    localparam int MPT_CNT_W = 32;
    localparam int MPT_NUM_MATCH = 7;
    localparam int MPT_NUM_OUT = 6;
    localparam int MPT_PERIOD_IDX = 0;
    localparam logic [MPT_CNT_W-1:0] MPT_CNT_RST = 32'h0000_0000;
    localparam logic [MPT_CNT_W-1:0] MPT_CNT_ONE = 32'h0000_0001;
    localparam logic [MPT_CNT_W-1:0] MPT_MATCH_RST = 32'h0000_0000;

    // Action taken by one match register when it hits
    typedef struct packed {
        logic int_en;
        logic reset_on;
        logic stop_on;
    } mpt_mctrl_t;

    localparam mpt_mctrl_t MPT_MCTRL_RST = '{int_en: 1'b0, reset_on: 1'b0, stop_on: 1'b0};

    // Global run controls
    typedef struct packed {
        logic cnt_en;
        logic pwm_en;
    } mpt_ctrl_t;

    typedef enum logic [1:0] {
        MPT_IDLE = 2'b00,
        MPT_RUN = 2'b01,
        MPT_HALT = 2'b11
    } mpt_state_t;

endpackage : mpt_pkg

/* File: logic/mpt_prescaler.sv */
// Prescaler: emits one tick every (prescale + 1) enabled clocks.
// Assumes the enable is a registered level from the parent.
module mpt_prescaler
    import mpt_pkg::*;
#(
    parameter int CNT_W = MPT_CNT_W
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [CNT_W-1:0] prescale,
    output logic tick_r
);

    logic [CNT_W-1:0] pc_r;
    logic [CNT_W-1:0] pc_nxt;
    logic tick_nxt;

    always_comb
    begin
        pc_nxt = pc_r;
        tick_nxt = 1'b0;
        if (!enable)
        begin
            pc_nxt = '0;
        end
        else if (pc_r >= prescale)
        begin
            // Terminal count also catches a prescale lowered below the live count
            pc_nxt = '0;
            tick_nxt = 1'b1;
        end
        else
        begin
            pc_nxt = pc_r + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            pc_r <= pc_nxt;
            tick_r <= tick_nxt;
        end
    end

endmodule : mpt_prescaler

/* File: logic/mpt_timer.sv */
// Top of the match based PWM timer: counter, seven match units, six outputs.
// Assumes synchronous control ports held by software; release and clear are pulses.
// Functional notes
// - 32-bit counter advances on ticks from a programmable 32-bit prescaler.
// - Seven match registers feed six single-edge or up to five double-edge outputs, mixed.
// - In PWM mode the period match register resets the counter when equal, setting the cycle rate.
// - Single-edge output rises at period match unless constant low; own match falls.
// - Double-edge output rises on one match, falls on another; either order.
// - Double-edge edges may sit at any counter position in the cycle.
// - Period and width are any whole count; all outputs share one period.
// - Each match may continue, stop or reset the counter, with optional interrupt.
// - In PWM mode new match values take effect only after release, in step with outputs.
// - With modulation disabled the block is a plain timer with match actions.
module mpt_timer
    import mpt_pkg::*;
#(
    parameter int CNT_W = MPT_CNT_W,
    parameter int NM = MPT_NUM_MATCH
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire mpt_ctrl_t ctrl,
    input wire logic [CNT_W-1:0] prescale,
    input wire logic [NM-1:0][CNT_W-1:0] match_val,
    input wire mpt_mctrl_t [NM-1:0] match_ctrl,
    input wire logic [NM-1:0] release_req,
    input wire logic [NM-2:0] dbl_sel,
    input wire logic [NM-1:0] flag_clr,
    output logic [CNT_W-1:0] count_r,
    output logic [NM-2:0] pwm_out_r,
    output logic [NM-1:0] flag_r,
    output logic [NM-1:0] pending_r,
    output logic halted_r
);

    function automatic logic hit(input logic tk, input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] val);
        hit = tk && (cnt == val);
    endfunction : hit

    mpt_state_t state_r;
    mpt_state_t state_nxt;
    logic tick;
    logic [NM-1:0] m;
    logic period_evt;
    logic any_rst;
    logic any_stop;
    logic [NM-1:0][CNT_W-1:0] active_r;
    logic [NM-1:0][CNT_W-1:0] active_nxt;
    logic [NM-1:0] pending_nxt;
    logic [NM-1:0] flag_nxt;
    logic [NM-2:0] pwm_nxt;
    logic [CNT_W-1:0] count_nxt;
    logic halted_nxt;

    mpt_prescaler #(.CNT_W(CNT_W)) u_presc (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .enable(state_r == MPT_RUN),
        .prescale(prescale),
        .tick_r(tick)
    );

    // Match detection and counter actions
    always_comb
    begin
        any_rst = 1'b0;
        any_stop = 1'b0;
        for (int i = 0; i < NM; i++)
        begin
            m[i] = hit(tick, count_r, active_r[i]);
            any_rst = any_rst | (m[i] & match_ctrl[i].reset_on);
            any_stop = any_stop | (m[i] & match_ctrl[i].stop_on);
        end
        period_evt = m[MPT_PERIOD_IDX] & ctrl.pwm_en;
        // Period match always wraps in PWM mode, whatever its action bits say
        any_rst = any_rst | period_evt;

        count_nxt = count_r;
        if (!ctrl.cnt_en)
        begin
            count_nxt = count_r;
        end
        else if (any_rst)
        begin
            count_nxt = MPT_CNT_RST;
        end
        else if (tick && !any_stop)
        begin
            count_nxt = count_r + MPT_CNT_ONE;
        end

        state_nxt = state_r;
        unique case (state_r)
            MPT_IDLE: if (ctrl.cnt_en) state_nxt = MPT_RUN;
            MPT_RUN:
            begin
                if (!ctrl.cnt_en)
                begin
                    state_nxt = MPT_IDLE;
                end
                else if (any_stop)
                begin
                    state_nxt = MPT_HALT;
                end
            end
            MPT_HALT: if (!ctrl.cnt_en) state_nxt = MPT_IDLE;
            default: state_nxt = MPT_IDLE;
        endcase
        halted_nxt = (state_nxt == MPT_HALT);
    end

    // Shadowed match values and release handshake
    always_comb
    begin
        active_nxt = active_r;
        pending_nxt = pending_r;
        for (int i = 0; i < NM; i++)
        begin
            if (!ctrl.pwm_en)
            begin
                // Plain timer: values act at once, nothing to keep glitch free
                active_nxt[i] = match_val[i];
                pending_nxt[i] = 1'b0;
            end
            else
            begin
                if (period_evt && pending_r[i])
                begin
                    active_nxt[i] = match_val[i];
                    pending_nxt[i] = 1'b0;
                end
                // A release in the apply cycle waits for the next period
                if (release_req[i])
                begin
                    pending_nxt[i] = 1'b1;
                end
            end
        end
    end

    // Output edges and pending interrupt flags
    always_comb
    begin
        pwm_nxt = pwm_out_r;
        for (int n = 1; n < NM; n++)
        begin
            if (!ctrl.pwm_en)
            begin
                pwm_nxt[n-1] = 1'b0;
            end
            else if (dbl_sel[n-1] && n > 1)
            begin
                // Fall wins when both edges share a count
                if (m[n])
                begin
                    pwm_nxt[n-1] = 1'b0;
                end
                else if (m[n-1])
                begin
                    pwm_nxt[n-1] = 1'b1;
                end
            end
            else
            begin
                // The value active in the new cycle decides the rise, so a switch to zero leaves no stray pulse
                if (period_evt && active_nxt[n] != MPT_MATCH_RST)
                begin
                    pwm_nxt[n-1] = 1'b1;
                end
                else if (m[n])
                begin
                    pwm_nxt[n-1] = 1'b0;
                end
            end
        end
        for (int i = 0; i < NM; i++)
        begin
            flag_nxt[i] = (flag_r[i] & ~flag_clr[i]) | (m[i] & match_ctrl[i].int_en);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= MPT_IDLE;
            count_r <= MPT_CNT_RST;
            active_r <= {NM{MPT_MATCH_RST}};
            pending_r <= '0;
            pwm_out_r <= '0;
            flag_r <= '0;
            halted_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            active_r <= active_nxt;
            pending_r <= pending_nxt;
            pwm_out_r <= pwm_nxt;
            flag_r <= flag_nxt;
            halted_r <= halted_nxt;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    AST_PERIOD_WRAP: assert property (ctrl.cnt_en && period_evt |=> count_r == MPT_CNT_RST)
        else $error("Counter did not wrap on period match");
    AST_COUNT_STEP: assert property (ctrl.cnt_en && tick && !any_rst && !any_stop
        |=> count_r == $past(count_r) + MPT_CNT_ONE)
        else $error("Counter did not advance on tick");
    AST_HOLD_NO_TICK: assert property (!tick |=> $stable(count_r))
        else $error("Counter moved without a prescaler tick");
    AST_SINGLE_RISE: assert property (period_evt && !m[1] && active_nxt[1] != MPT_MATCH_RST
        |=> pwm_out_r[0])
        else $error("Single edge output did not rise at period start");
    AST_SINGLE_FALL: assert property (ctrl.pwm_en && m[1] && !period_evt |=> !pwm_out_r[0])
        else $error("Single edge output did not fall on its match");
    AST_DOUBLE_RISE: assert property (ctrl.pwm_en && dbl_sel[1] && m[1] && !m[2] |=> pwm_out_r[1])
        else $error("Double edge output did not rise");
    AST_STOP_HALT: assert property (state_r == MPT_RUN && ctrl.cnt_en && any_stop
        |=> halted_r ##1 halted_r [*2])
        else $error("Stop action did not halt the counter");
    AST_SHADOW_SYNC: assert property (ctrl.pwm_en && !period_evt |=> $stable(active_r))
        else $error("Active match value changed mid cycle");
    AST_RELEASE_APPLY: assert property (ctrl.pwm_en && period_evt && pending_r[1]
        |=> active_r[1] == $past(match_val[1]) && pending_r[1] == $past(release_req[1]))
        else $error("Released value not applied at period match");
    AST_TIMER_MODE: assert property (!ctrl.pwm_en |=> pwm_out_r == '0)
        else $error("Outputs active in plain timer mode");
    AST_FLAG_SET: assert property (m[2] && match_ctrl[2].int_en |=> flag_r[2])
        else $error("Interrupt flag not set on match");

    COV_PERIOD: cover property (period_evt ##[1:40] period_evt);
    COV_DOUBLE: cover property (dbl_sel[1] && pwm_out_r[1] ##[1:40] !pwm_out_r[1]);
    COV_STOP: cover property (state_r == MPT_RUN ##1 state_r == MPT_HALT);
    COV_RELEASE: cover property (pending_r[3] ##[1:40] !pending_r[3]);

endmodule : mpt_timer

/* File: testbench/mpt_load_model.sv */
// Load model: a drive stage that totals the on-time of each modulated output.
// Assumes registered outputs on ref_clk; clear is a one-cycle pulse from the bench.
module mpt_load_model
    import mpt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clear,
    input wire logic [MPT_NUM_OUT-1:0] drive,
    output logic [MPT_NUM_OUT-1:0][15:0] on_cnt
);
    timeunit 1ns;
    timeprecision 1ns;

    // A drive stage only listens, so it never loads the outputs back
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < MPT_NUM_OUT; i++)
        begin
            on_cnt[i] <= clear ? 16'h0000 : on_cnt[i] + 16'(drive[i]);
        end
    end
endmodule : mpt_load_model

/* File: testbench/testbench.sv */
// Bench for the match based PWM timer: random modulation rounds, then a plain timer pass.
// Assumes the load model sums on-time; inputs change 1 ns after each rising edge.
module testbench
    import mpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    mpt_ctrl_t ctrl = '0;
    logic [31:0] prescale = '0;
    logic [6:0][31:0] match_val = '0;
    mpt_mctrl_t [6:0] match_ctrl = '0;
    logic [6:0] release_req = '0;
    logic [5:0] dbl_sel = '0;
    logic [6:0] flag_clr = '0;
    logic [31:0] count_r;
    logic [5:0] pwm_out_r;
    logic [6:0] flag_r;
    logic [6:0] pending_r;
    logic halted_r;
    logic clear = 1'b0;
    logic [5:0][15:0] on_cnt;
    logic [6:0][31:0] am = '0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int s;
    int t;

    mpt_timer mpt_timer_inst (.ref_clk(ref_clk), .reset_n(reset_n), .ctrl(ctrl), .prescale(prescale),
        .match_val(match_val), .match_ctrl(match_ctrl), .release_req(release_req), .dbl_sel(dbl_sel),
        .flag_clr(flag_clr), .count_r(count_r), .pwm_out_r(pwm_out_r), .flag_r(flag_r),
        .pending_r(pending_r), .halted_r(halted_r));
    mpt_load_model mpt_load_model_inst (.ref_clk(ref_clk), .clear(clear), .drive(pwm_out_r), .on_cnt(on_cnt));

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    // Ceiling is roughly thirty times the longest expected run
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic check(logic [31:0] seen, logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step

    // Double outputs rise after match n-1 and fall after match n; a tie stays low
    function automatic logic exp_out(int n, logic [31:0] c);
        logic [31:0] a;
        logic [31:0] b;
        a = am[n-1];
        b = am[n];
        if (n > 1 && dbl_sel[n-1])
            return (a == b) ? 1'b0 : (a < b) ? (c > a && c <= b) : (c > a || c <= b);
        return (b != 0) && (c <= b);
    endfunction : exp_out

    task automatic check_pwm(int k);
        repeat (k)
        begin
            step();
            check(count_r <= am[0], 1);
            for (int n = 1; n < 7; n++)
                check(pwm_out_r[n-1], exp_out(n, count_r));
        end
    endtask : check_pwm

    task automatic round(logic [5:0] d, int p, bit corner, bit chk);
        logic [6:0][31:0] nv;
        int e;
        nv[0] = p;
        for (int i = 1; i < 7; i++)
            nv[i] = $urandom_range(p - 1, 1);
        if (corner)
        begin
            nv[5] = p + 1;
            nv[6] = '0;
        end
        match_val = nv;
        if (chk)
            check_pwm(p + 1);
        // Releasing at count 1 keeps clear of the apply cycle
        for (int i = 0; i < 50 && count_r !== 1; i++)
            step();
        release_req = '1;
        step();
        release_req = '0;
        check(pending_r, 7'h7f);
        for (int i = 0; i < 50 && pending_r !== 0; i++)
            step();
        check(count_r, 0);
        am = nv;
        dbl_sel = d;
        repeat (2 * p + 4)
            step();
        check_pwm(2 * p + 2);
        for (int i = 0; i < 50 && count_r !== p; i++)
            step();
        clear = 1'b1;
        step();
        clear = 1'b0;
        repeat (p + 1)
            step();
        for (int n = 1; n < 7; n++)
        begin
            e = 0;
            for (int c = 0; c <= p; c++)
                e += exp_out(n, c);
            check(on_cnt[n-1], e);
        end
    endtask : round

    initial
    begin
        void'($urandom(32'ha067b2c8));
        repeat (10)
            @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        check(count_r, 0);
        check({pwm_out_r, flag_r, pending_r, halted_r}, 0);
        ctrl = '{cnt_en: 1'b1, pwm_en: 1'b1};
        round(6'h00, 6, 1'b0, 1'b0);
        round(6'h00, 9, 1'b1, 1'b1);
        round(6'h2a, 8, 1'b0, 1'b1);
        repeat (4)
            round(6'($urandom), $urandom_range(12, 3), 1'b0, 1'b1);
        // Plain timer pass starts from a second reset so the count begins at zero
        ctrl = '0;
        reset_n = 1'b0;
        step();
        reset_n = 1'b1;
        prescale = $urandom_range(3, 1);
        s = $urandom_range(12, 5);
        match_val = '1;
        match_val[2] = s;
        match_ctrl[2] = '{int_en: 1'b1, reset_on: 1'b1, stop_on: 1'b0};
        ctrl.cnt_en = 1'b1;
        for (int i = 0; i < 40 && count_r !== 2; i++)
            step();
        for (t = 0; t < 20 && count_r === 2; t++)
            step();
        check(t, prescale + 1);
        repeat (4 * (s + 1) * (prescale + 1))
        begin
            step();
            check(count_r <= s, 1);
            check(pwm_out_r, 0);
        end
        check(flag_r, 7'h04);
        for (int i = 0; i < 60 && count_r !== 1; i++)
            step();
        flag_clr = 7'h04;
        step();
        flag_clr = '0;
        check(flag_r, 0);
        match_ctrl[2] = '{int_en: 1'b1, reset_on: 1'b0, stop_on: 1'b1};
        repeat ((s + 2) * (prescale + 1))
            step();
        check(halted_r, 1);
        check(count_r, s);
        ctrl.cnt_en = 1'b0;
        repeat (2)
            step();
        check(halted_r, 0);
        close_out();
    end
endmodule : testbench
